// ---- rtl/dofs_top.sv ----
// Function selector for two digital outputs and one digital input of a drive.
// Assumes a parameter access port with single-cycle strobes, synchronous status
// inputs, and a power-up pulse from the supervisor after each power-on.
`timescale 1ns/1ns
`include "dofs_params.svh"
module dofs_top (
    input  wire logic             clock,
    input  wire logic             rst,
    // Supervisor
    input  wire logic             powerUp,
    input  wire logic             powerStageOn,
    // Parameter access
    input  wire logic             paramWrite,
    input  wire logic             paramRead,
    input  wire logic [15:0]      paramAddr,
    input  wire logic [15:0]      paramWrData,
    output logic      [15:0]      paramRdData,
    output logic                  paramAck,
    output logic                  paramReject,
    // Generic output values
    input  wire logic [1:0]       genericOut,
    // Drive status
    input  wire logic             opReady,
    input  wire logic             opSwitched,
    input  wire logic             opEnabled,
    input  wire logic             capActive,
    input  wire logic             capDone,
    input  wire logic             posWin,
    input  wire logic             velWin,
    input  wire logic             velLow,
    input  wire logic             curLow,
    input  wire logic             haltAck,
    input  wire logic             standstill,
    input  wire logic [4:0]       selErr,
    input  wire logic             refOk,
    input  wire logic [3:0]       posReg,
    input  wire logic             movePos,
    input  wire logic             moveNeg,
    // Pins
    input  wire logic             digitalInput,
    output logic                  digitalOutput0,
    output logic                  digitalOutput1,
    // Decoded input functions
    output logic                  positiveLimitInput,
    output logic                  negativeLimitInput,
    output logic                  paramSetSelect,
    output logic                  integralOff,
    output logic                  moveAfterCaptureStart,
    output logic                  moveAfterCaptureArm,
    output logic                  brakeRelease
);
    dofs_pkg::dofs_main_s state_ff;
    dofs_pkg::dofs_main_s nxt_state;

    wire logic [1:0]              outPins;
    logic                         addrHit;
    logic [1:0]                   addrIdx;
    logic                         codeOk;

    // Valid output codes
    function automatic logic outValid(input dofs_pkg::dofs_code_t c);
        outValid = (c >= `DOFS_O_FREE && c <= `DOFS_O_HALTACK) ||
                   (c >= `DOFS_O_STILL && c <= `DOFS_O_SELWRN) ||
                   (c >= `DOFS_O_PRC1 && c <= `DOFS_O_MOVNEG);
    endfunction : outValid

    // Valid input codes
    function automatic logic inValid(input dofs_pkg::dofs_code_t c);
        inValid = (c >= `DOFS_I_FREE && c <= `DOFS_I_LAST_GEN) ||
                  (c >= `DOFS_I_REF && c <= `DOFS_I_PSET) ||
                  (c == `DOFS_I_IOFF) || (c == `DOFS_I_RSTART) ||
                  (c == `DOFS_I_RARM) || (c == `DOFS_I_BRAKE);
    endfunction : inValid

    // Address decode
    always_comb begin
        addrHit = 1'b1;
        addrIdx = 2'h0;
        unique case (paramAddr)
            `DOFS_OFS_OUT0: addrIdx = 2'h0;
            `DOFS_OFS_OUT1: addrIdx = 2'h1;
            `DOFS_OFS_IN0:  addrIdx = 2'h2;
            default:        addrHit = 1'b0;
        endcase
    end

    // Code check per target
    always_comb begin
        if (addrIdx == 2'h2) begin
            codeOk = inValid(paramWrData);
        end else begin
            codeOk = outValid(paramWrData);
        end
    end

    // Parameter access and power-up load
    always_comb begin
        nxt_state = state_ff;
        nxt_state.ack = 1'b0;
        nxt_state.reject = 1'b0;
        if (paramWrite) begin
            nxt_state.ack = 1'b1;
            if (!addrHit || powerStageOn) begin
                nxt_state.reject = 1'b1;
            end else if (!codeOk) begin
                nxt_state.reject = 1'b1;
            end else begin
                nxt_state.stored[addrIdx] = paramWrData;
            end
        end else if (paramRead) begin
            nxt_state.ack = 1'b1;
            if (addrHit) begin
                nxt_state.rdData = state_ff.stored[addrIdx];
            end else begin
                nxt_state.rdData = 16'h0000;
                nxt_state.reject = 1'b1;
            end
        end
        if (powerUp) begin
            nxt_state.active = state_ff.stored;
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff.stored <= {3{`DOFS_RST_CODE}};
            state_ff.active <= {3{`DOFS_RST_CODE}};
            state_ff.rdData <= 16'h0000;
            state_ff.ack    <= 1'b0;
            state_ff.reject <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Output selectors, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gOut
            dofs_out_mux i_dofs_out_mux (
                .clock      (clock),
                .rst        (rst),
                .code       (state_ff.active[gi]),
                .generic    (genericOut[gi]),
                .opReady    (opReady),
                .opSwitched (opSwitched),
                .opEnabled  (opEnabled),
                .capActive  (capActive),
                .capDone    (capDone),
                .posWin     (posWin),
                .velWin     (velWin),
                .velLow     (velLow),
                .curLow     (curLow),
                .haltAck    (haltAck),
                .standstill (standstill),
                .selErr     (selErr),
                .refOk      (refOk),
                .posReg     (posReg),
                .movePos    (movePos),
                .moveNeg    (moveNeg),
                .pinOut     (outPins[gi])
            );
        end
    endgenerate

    // Input function decoder
    dofs_in_decode i_dofs_in_decode (
        .clock        (clock),
        .rst          (rst),
        .code         (state_ff.active[2]),
        .pinIn        (digitalInput),
        .posLimit     (positiveLimitInput),
        .negLimit     (negativeLimitInput),
        .paramSet     (paramSetSelect),
        .integralOff  (integralOff),
        .capStart     (moveAfterCaptureStart),
        .capArm       (moveAfterCaptureArm),
        .brakeRelease (brakeRelease)
    );

    // Registered outputs
    assign digitalOutput0 = outPins[0];
    assign digitalOutput1 = outPins[1];
    assign paramRdData    = state_ff.rdData;
    assign paramAck       = state_ff.ack;
    assign paramReject    = state_ff.reject;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Write to output 0 while power stage on
    sequence sWriteOnHot;
        paramWrite && powerStageOn && paramAddr == `DOFS_OFS_OUT0;
    endsequence

    // Write of an unlisted output code while power stage off
    sequence sWriteBadCode;
        paramWrite && !powerStageOn && paramAddr == `DOFS_OFS_OUT1 && !outValid(paramWrData);
    endsequence

    // Good write followed by power-up
    sequence sGoodWriteThenPowerUp;
        (paramWrite && !powerStageOn && paramAddr == `DOFS_OFS_OUT0 && outValid(paramWrData))
        ##1 (!paramWrite && powerUp);
    endsequence

    // Read of output 0 selection
    sequence sReadOut0;
        paramRead && !paramWrite && paramAddr == `DOFS_OFS_OUT0;
    endsequence

    // Access to an offset with no parameter
    sequence sUnmapped;
        (paramRead || paramWrite) && paramAddr != `DOFS_OFS_OUT0 &&
        paramAddr != `DOFS_OFS_OUT1 && paramAddr != `DOFS_OFS_IN0;
    endsequence

    // Unlisted input code while power stage off
    sequence sWriteBadInput;
        paramWrite && !powerStageOn && paramAddr == `DOFS_OFS_IN0 && !inValid(paramWrData);
    endsequence

    // Listed code to output 1 while power stage off
    sequence sGoodOut1;
        paramWrite && !powerStageOn && paramAddr == `DOFS_OFS_OUT1 && outValid(paramWrData);
    endsequence

    AST_REJECT_HOT: assert property (sWriteOnHot |=> paramAck && paramReject)
        else $error("write during power stage on not refused");

    AST_KEEP_HOT: assert property (sWriteOnHot |=> $stable(state_ff.stored[0]))
        else $error("stored code changed while power stage on");

    AST_REJECT_BAD: assert property (sWriteBadCode |=> paramReject ##0 $stable(state_ff.stored[1]))
        else $error("unlisted code accepted");

    AST_NO_EARLY: assert property (!powerUp |=> $stable(state_ff.active))
        else $error("selection changed without power-up");

    AST_APPLY: assert property (sGoodWriteThenPowerUp |=> state_ff.active[0] == $past(paramWrData, 2))
        else $error("written code not applied at power-up");

    AST_ACK: assert property ((paramWrite || paramRead) |=> paramAck)
        else $error("access not acknowledged next cycle");

    AST_ACK_IDLE: assert property (!paramWrite && !paramRead |=> !paramAck)
        else $error("answer without access");

    AST_REJECT_ACK: assert property (paramReject |-> paramAck)
        else $error("refusal without answer");

    AST_READ_OUT0: assert property (sReadOut0 |=> paramRdData == $past(state_ff.stored[0]) && !paramReject)
        else $error("read data differs from stored code");

    AST_UNMAPPED: assert property (sUnmapped |=> paramReject)
        else $error("unmapped access not refused");

    AST_REJECT_IN: assert property (sWriteBadInput |=> paramReject ##0 $stable(state_ff.stored[2]))
        else $error("unlisted input code accepted");

    AST_STORE_OUT1: assert property (sGoodOut1 |=> state_ff.stored[1] == $past(paramWrData) && !paramReject)
        else $error("listed code not stored");
endmodule : dofs_top

// ---- rtl/dofs_params.svh ----
// Constants of the digital I/O function selector: offsets, reset codes, function codes.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DOFS_PARAMS_SVH
`define DOFS_PARAMS_SVH
// Parameter offsets
`define DOFS_OFS_OUT0    16'h0712
`define DOFS_OFS_OUT1    16'h0714
`define DOFS_OFS_IN0     16'h0708
// Reset selection: freely available
`define DOFS_RST_CODE    16'h0001
// Output function codes
`define DOFS_O_FREE      16'h0001
`define DOFS_O_NOFAULT   16'h0002
`define DOFS_O_ACTIVE    16'h0003
`define DOFS_O_CAPMOVE   16'h0004
`define DOFS_O_POSWIN    16'h0005
`define DOFS_O_VELWIN    16'h0006
`define DOFS_O_VELTHR    16'h0007
`define DOFS_O_CURTHR    16'h0008
`define DOFS_O_HALTACK   16'h0009
`define DOFS_O_STILL     16'h000D
`define DOFS_O_SELERR    16'h000E
`define DOFS_O_REFOK     16'h000F
`define DOFS_O_SELWRN    16'h0010
`define DOFS_O_PRC1      16'h0012
`define DOFS_O_PRC4      16'h0015
`define DOFS_O_MOVPOS    16'h0016
`define DOFS_O_MOVNEG    16'h0017
// Position register channel index offset
`define DOFS_PRC_BASE    2'h2
// Input function codes
`define DOFS_I_FREE      16'h0001
`define DOFS_I_LAST_GEN  16'h0008
`define DOFS_I_REF       16'h0015
`define DOFS_I_POSLIM    16'h0016
`define DOFS_I_NEGLIM    16'h0017
`define DOFS_I_PSET      16'h0018
`define DOFS_I_IOFF      16'h001C
`define DOFS_I_RSTART    16'h001E
`define DOFS_I_RARM      16'h001F
`define DOFS_I_BRAKE     16'h0028
// Error class field: bit 0 warning, bits 1..4 error classes
`define DOFS_ERR_WARN    0
`define DOFS_ERR_LO      1
`define DOFS_ERR_HI      4
`endif

// ---- rtl/dofs_pkg.sv ----
// Types of the digital I/O function selector.
// Assumes nothing of its surroundings.
package dofs_pkg;
    typedef logic [15:0] dofs_code_t;
    typedef struct packed {
        logic pinOut;
    } dofs_omux_s;
    typedef struct packed {
        logic posLimit;
        logic negLimit;
        logic paramSet;
        logic integralOff;
        logic capStart;
        logic capArm;
        logic brakeRelease;
        logic pinPrev;
    } dofs_idec_s;
    typedef struct packed {
        dofs_code_t [2:0] stored;
        dofs_code_t [2:0] active;
        dofs_code_t       rdData;
        logic             ack;
        logic             reject;
    } dofs_main_s;
endpackage : dofs_pkg

// ---- rtl/dofs_out_mux.sv ----
// Selector of one digital output: picks one status condition by the active code.
// Assumes the active code only changes on power-up and status inputs are synchronous.
`timescale 1ns/1ns
`include "dofs_params.svh"
module dofs_out_mux (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire dofs_pkg::dofs_code_t code,
    input  wire logic             generic,
    input  wire logic             opReady,
    input  wire logic             opSwitched,
    input  wire logic             opEnabled,
    input  wire logic             capActive,
    input  wire logic             capDone,
    input  wire logic             posWin,
    input  wire logic             velWin,
    input  wire logic             velLow,
    input  wire logic             curLow,
    input  wire logic             haltAck,
    input  wire logic             standstill,
    input  wire logic [4:0]       selErr,
    input  wire logic             refOk,
    input  wire logic [3:0]       posReg,
    input  wire logic             movePos,
    input  wire logic             moveNeg,
    output logic                  pinOut
);
    dofs_pkg::dofs_omux_s state_ff;
    dofs_pkg::dofs_omux_s nxt_state;

    // Source selection by code
    always_comb begin
        nxt_state = state_ff;
        unique case (code)
            `DOFS_O_FREE:    nxt_state.pinOut = generic;
            `DOFS_O_NOFAULT: nxt_state.pinOut = opReady | opSwitched | opEnabled;
            `DOFS_O_ACTIVE:  nxt_state.pinOut = opEnabled;
            `DOFS_O_CAPMOVE: nxt_state.pinOut = capActive | capDone;
            `DOFS_O_POSWIN:  nxt_state.pinOut = posWin;
            `DOFS_O_VELWIN:  nxt_state.pinOut = velWin;
            `DOFS_O_VELTHR:  nxt_state.pinOut = velLow;
            `DOFS_O_CURTHR:  nxt_state.pinOut = curLow;
            `DOFS_O_HALTACK: nxt_state.pinOut = haltAck;
            `DOFS_O_STILL:   nxt_state.pinOut = standstill;
            `DOFS_O_SELERR:  nxt_state.pinOut = |selErr[`DOFS_ERR_HI:`DOFS_ERR_LO];
            `DOFS_O_REFOK:   nxt_state.pinOut = refOk;
            `DOFS_O_SELWRN:  nxt_state.pinOut = selErr[`DOFS_ERR_WARN];
            `DOFS_O_MOVPOS:  nxt_state.pinOut = movePos;
            `DOFS_O_MOVNEG:  nxt_state.pinOut = moveNeg;
            default: begin
                if (code >= `DOFS_O_PRC1 && code <= `DOFS_O_PRC4) begin
                    nxt_state.pinOut = posReg[2'(code[1:0] - `DOFS_PRC_BASE)];
                end else begin
                    nxt_state.pinOut = 1'b0;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign pinOut = state_ff.pinOut;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_FREE_GENERIC: assert property (code == `DOFS_O_FREE |=> pinOut == $past(generic))
        else $error("free output does not follow generic value");
    AST_NOFAULT: assert property (code == `DOFS_O_NOFAULT && !opReady && !opSwitched && !opEnabled |=> !pinOut)
        else $error("no fault output set outside ready states");
    AST_ACTIVE: assert property (code == `DOFS_O_ACTIVE |=> pinOut == $past(opEnabled))
        else $error("active output does not follow operation enabled");
    AST_PRC: assert property (code == `DOFS_O_PRC4 |=> pinOut == $past(posReg[3]))
        else $error("channel four not routed");
endmodule : dofs_out_mux

// ---- rtl/dofs_in_decode.sv ----
// Decoder of one digital input into its selected drive function.
// Assumes the pin is synchronous and the active code only changes on power-up.
`timescale 1ns/1ns
`include "dofs_params.svh"
module dofs_in_decode (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire dofs_pkg::dofs_code_t code,
    input  wire logic             pinIn,
    output logic                  posLimit,
    output logic                  negLimit,
    output logic                  paramSet,
    output logic                  integralOff,
    output logic                  capStart,
    output logic                  capArm,
    output logic                  brakeRelease
);
    dofs_pkg::dofs_idec_s state_ff;
    dofs_pkg::dofs_idec_s nxt_state;

    // Function outputs by code
    always_comb begin
        nxt_state = state_ff;
        nxt_state.pinPrev = pinIn;
        nxt_state.posLimit = (code == `DOFS_I_POSLIM) & pinIn;
        nxt_state.negLimit = (code == `DOFS_I_NEGLIM) & pinIn;
        nxt_state.paramSet = (code == `DOFS_I_PSET) & pinIn;
        nxt_state.integralOff = (code == `DOFS_I_IOFF) & pinIn;
        nxt_state.capStart = (code == `DOFS_I_RSTART) & pinIn & ~state_ff.pinPrev;
        nxt_state.capArm = (code == `DOFS_I_RARM) & pinIn;
        nxt_state.brakeRelease = (code == `DOFS_I_BRAKE) & pinIn;
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign posLimit     = state_ff.posLimit;
    assign negLimit     = state_ff.negLimit;
    assign paramSet     = state_ff.paramSet;
    assign integralOff  = state_ff.integralOff;
    assign capStart     = state_ff.capStart;
    assign capArm       = state_ff.capArm;
    assign brakeRelease = state_ff.brakeRelease;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_POSLIM: assert property (code == `DOFS_I_POSLIM |=> posLimit == $past(pinIn) && !negLimit)
        else $error("positive limit not following pin");
    AST_START_PULSE: assert property (capStart |=> !capStart)
        else $error("start trigger longer than one cycle");
endmodule : dofs_in_decode

// ---- test/dofs_ext_ctrl.sv ----
// External controller model: drives the block's digital input pin.
// Assumes the controller shares the block clock and the bench sets the level.
`timescale 1ns/1ns
module dofs_ext_ctrl (
    input  wire logic clock,
    input  wire logic pinLevel,
    output logic      digitalInput
);
    // Pin launched one edge after the bench asks for it
    always_ff @(posedge clock) begin
        digitalInput <= pinLevel;
    end
endmodule : dofs_ext_ctrl

// ---- test/test_dofs_top.sv ----
// Testbench of the digital I/O function selector: codes, refusals, output and input selection.
// Assumes answers one cycle after a taken request and new codes applied on powerUp.
`timescale 1ns/1ns
`include "dofs_params.svh"
module test_dofs_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        powerUp = 1'b0;
    logic        powerStageOn = 1'b0;
    logic        paramWrite = 1'b0;
    logic        paramRead = 1'b0;
    logic [15:0] paramAddr = 16'h0000;
    logic [15:0] paramWrData = 16'h0000;
    logic [1:0]  genericOut = 2'h0;
    logic [22:0] stat = 23'h000000;
    logic        pinLevel = 1'b0;
    logic [15:0] paramRdData;
    logic        paramAck, paramReject, digitalInput, dout0, dout1;
    logic [6:0]  dec;
    logic [15:0] act [2] = '{`DOFS_RST_CODE, `DOFS_RST_CODE};
    int          mismatches = 0;
    int          totalChecks = 0;

    // Clock of 4 ns
    always #2 clock = ~clock;

    dofs_top i_dofs_top (
        .clock(clock), .rst(rst), .powerUp(powerUp), .powerStageOn(powerStageOn),
        .paramWrite(paramWrite), .paramRead(paramRead), .paramAddr(paramAddr), .paramWrData(paramWrData),
        .paramRdData(paramRdData), .paramAck(paramAck), .paramReject(paramReject), .genericOut(genericOut),
        .opReady(stat[0]), .opSwitched(stat[1]), .opEnabled(stat[2]), .capActive(stat[3]), .capDone(stat[4]),
        .posWin(stat[5]), .velWin(stat[6]), .velLow(stat[7]), .curLow(stat[8]), .haltAck(stat[9]),
        .standstill(stat[10]), .selErr(stat[15:11]), .refOk(stat[16]), .posReg(stat[20:17]),
        .movePos(stat[21]), .moveNeg(stat[22]), .digitalInput(digitalInput),
        .digitalOutput0(dout0), .digitalOutput1(dout1),
        .positiveLimitInput(dec[6]), .negativeLimitInput(dec[5]), .paramSetSelect(dec[4]),
        .integralOff(dec[3]), .moveAfterCaptureStart(dec[2]), .moveAfterCaptureArm(dec[1]),
        .brakeRelease(dec[0])
    );
    dofs_ext_ctrl i_dofs_ext_ctrl (.clock(clock), .pinLevel(pinLevel), .digitalInput(digitalInput));

    // Listed output codes
    function automatic logic listed(input logic [15:0] c);
        return (c >= 16'h0001 && c <= 16'h0009) || (c >= 16'h000D && c <= 16'h0010) ||
               (c >= 16'h0012 && c <= 16'h0017);
    endfunction : listed

    // Expected pin level for a code and a status pattern
    function automatic logic expf(input logic [15:0] c, input logic [22:0] s, input logic g);
        case (c) inside
            16'h0001: return g;
            16'h0002: return |s[2:0];
            16'h0003: return s[2];
            16'h0004: return s[3] | s[4];
            [16'h0005:16'h0009]: return s[c[3:0]];
            16'h000D: return s[10];
            16'h000E: return |s[15:12];
            16'h000F: return s[16];
            16'h0010: return s[11];
            [16'h0012:16'h0015]: return s[c - 16'h0001];
            16'h0016: return s[21];
            16'h0017: return s[22];
            default: return 1'b0;
        endcase
    endfunction : expf

    task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
        totalChecks++;
        if (got !== expv) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, expv, got);
        end
    endtask : chk

    task automatic endSim();
        $display("Checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : endSim

    // One parameter access; answer judged one cycle after it is taken
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data, input logic rej);
        @(posedge clock);
        paramWrite <= wr;
        paramRead <= !wr;
        paramAddr <= addr;
        paramWrData <= data;
        @(posedge clock);
        paramWrite <= 1'b0;
        paramRead <= 1'b0;
        #1;
        chk("ack", 16'h0001, {15'h0000, paramAck});
        chk("reject", {15'h0000, rej}, {15'h0000, paramReject});
    endtask : access

    task automatic powerOn();
        @(posedge clock);
        powerUp <= 1'b1;
        @(posedge clock);
        powerUp <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : powerOn

    // Apply status and generic values, then judge both outputs
    task automatic outs(input logic [22:0] s, input logic [1:0] g);
        @(posedge clock);
        stat <= s;
        genericOut <= g;
        repeat (2) @(posedge clock);
        #1;
        chk("outputs", {14'h0000, expf(act[1], s, g[1]), expf(act[0], s, g[0])}, {14'h0000, dout1, dout0});
    endtask : outs

    task automatic test_reset();
        access(1'b0, `DOFS_OFS_OUT0, 16'h0000, 1'b0);
        chk("out0 code", `DOFS_RST_CODE, paramRdData);
        access(1'b0, `DOFS_OFS_OUT1, 16'h0000, 1'b0);
        chk("out1 code", `DOFS_RST_CODE, paramRdData);
        outs(23'h7FFFFF, 2'h2);
        outs(23'h7FFFFF, 2'h1);
    endtask : test_reset

    task automatic test_out_codes(input int n);
        logic [15:0] addr;
        addr = n ? `DOFS_OFS_OUT1 : `DOFS_OFS_OUT0;
        for (logic [15:0] c = 16'h0000; c < 16'h0019; c++) begin
            access(1'b1, addr, c, !listed(c));
            access(1'b0, addr, 16'h0000, 1'b0);
            chk("stored code", listed(c) ? c : act[n], paramRdData);
            if (listed(c)) begin
                outs(23'h555555, 2'h1);
                powerOn();
                act[n] = c;
                for (int b = 0; b < 23; b++) begin
                    outs(23'h000001 << b, 2'h0);
                end
            end
        end
    endtask : test_out_codes

    task automatic test_refusals();
        @(posedge clock);
        powerStageOn <= 1'b1;
        access(1'b1, `DOFS_OFS_OUT1, `DOFS_O_ACTIVE, 1'b1);
        access(1'b0, `DOFS_OFS_OUT1, 16'h0000, 1'b0);
        chk("locked code", act[1], paramRdData);
        @(posedge clock);
        powerStageOn <= 1'b0;
        access(1'b0, 16'h0710, 16'h0000, 1'b1);
        chk("unmapped read", 16'h0000, paramRdData);
    endtask : test_refusals

    // Raise the pin, judge decoded functions, then drop it
    task automatic pinPulse(input logic [6:0] first, input logic [6:0] later);
        @(posedge clock);
        pinLevel <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk("decoded", {9'h000, first}, {9'h000, dec});
        @(posedge clock);
        #1;
        chk("decoded held", {9'h000, later}, {9'h000, dec});
        @(posedge clock);
        pinLevel <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        chk("decoded idle", 16'h0000, {9'h000, dec});
    endtask : pinPulse

    task automatic test_apply();
        @(posedge clock);
        paramWrite <= 1'b1;
        paramAddr <= `DOFS_OFS_OUT0;
        paramWrData <= `DOFS_O_ACTIVE;
        @(posedge clock);
        paramWrite <= 1'b0;
        powerUp <= 1'b1;
        #1;
        chk("apply ack", 16'h0001, {15'h0000, paramAck});
        @(posedge clock);
        powerUp <= 1'b0;
        act[0] = `DOFS_O_ACTIVE;
        outs(23'h000004, 2'h0);
        outs(23'h000003, 2'h1);
    endtask : test_apply

    task automatic test_inputs();
        logic [15:0] codes [7];
        logic [6:0]  bits [7];
        codes = '{`DOFS_I_POSLIM, `DOFS_I_NEGLIM, `DOFS_I_PSET, `DOFS_I_IOFF, `DOFS_I_RSTART, `DOFS_I_RARM, `DOFS_I_BRAKE};
        bits = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
        access(1'b1, `DOFS_OFS_IN0, 16'h0019, 1'b1);
        for (int i = 0; i < 7; i++) begin
            access(1'b1, `DOFS_OFS_IN0, codes[i], 1'b0);
            powerOn();
            pinPulse(bits[i], (i == 4) ? 7'h00 : bits[i]);
        end
    endtask : test_inputs

    // Main sequence after a 10-cycle reset
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        test_reset();
        test_out_codes(0);
        test_out_codes(1);
        test_refusals();
        test_apply();
        test_inputs();
        endSim();
    end

    // Watchdog well beyond the expected run
    initial begin
        #100000;
        mismatches++;
        endSim();
    end
endmodule : test_dofs_top
